// ==== acd_pkg.sv ====
// Constants and types for the converter command decoder
package acd_pkg;
	localparam int WORD_BITS   = 16;
	localparam int OPCODE_BITS = 4;
	localparam int CONFIG_BITS = 12;

	// Operation codes carried in the top four bits of each input word
	localparam logic [3:0] OP_CHANNEL_LAST = 4'h7;
	localparam logic [3:0] OP_POWER_DOWN   = 4'h8;
	localparam logic [3:0] OP_CONFIG_READ  = 4'h9;
	localparam logic [3:0] OP_CONFIG_WRITE = 4'ha;
	localparam logic [3:0] OP_TEST_MID     = 4'hb;
	localparam logic [3:0] OP_TEST_LOW     = 4'hc;
	localparam logic [3:0] OP_TEST_HIGH    = 4'hd;
	localparam logic [3:0] OP_FIFO_READ    = 4'he;
	localparam logic [3:0] OP_RESERVED     = 4'hf;

	// Configuration word field positions
	localparam int CFG_REF_SOURCE_BIT = 11;
	localparam int CFG_REF_LEVEL_BIT  = 10;
	localparam int CFG_SAMPLE_BIT     = 9;
	localparam int CFG_CLOCK_MSB      = 8;
	localparam int CFG_CLOCK_LSB      = 7;
	localparam int CFG_MODE_MSB       = 6;
	localparam int CFG_MODE_LSB       = 5;
	localparam int CFG_SWEEP_MSB      = 4;
	localparam int CFG_SWEEP_LSB      = 3;
	localparam int CFG_PIN_FUNC_BIT   = 2;
	localparam int CFG_TRIGGER_MSB    = 1;
	localparam int CFG_TRIGGER_LSB    = 0;

	localparam logic [11:0] CONFIG_RESET = 12'h000;

	// Sampling lengths in serial clocks
	localparam logic [4:0] SHORT_SAMPLE_SCLKS = 5'h0c;
	localparam logic [4:0] LONG_SAMPLE_SCLKS  = 5'h18;

	// FIFO levels that raise the interrupt, per trigger code
	localparam logic [2:0] TRIGGER_LEVEL_FULL    = 3'h7;
	localparam logic [2:0] TRIGGER_LEVEL_3Q      = 3'h5;
	localparam logic [2:0] TRIGGER_LEVEL_HALF    = 3'h3;
	localparam logic [2:0] TRIGGER_LEVEL_QUARTER = 3'h1;

	typedef enum logic [1:0] {
		clk_internal_oscillator,
		clk_serial,
		clk_serial_div4,
		clk_serial_div2
	} acd_conv_clock_type;

	typedef enum logic [1:0] {
		mode_single_shot,
		mode_repeat,
		mode_sweep,
		mode_repeat_sweep
	} acd_conv_mode_type;

	typedef enum logic [1:0] {
		test_none,
		test_midpoint,
		test_low_reference,
		test_high_reference
	} acd_test_input_type;

	typedef enum {
		st_idle,
		st_shift,
		st_done
	} acd_frame_state_type;
endpackage : acd_pkg

// ==== acd_sync.sv ====
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module acd_sync #(
	parameter int          WIDTH      = 1,
	parameter logic [31:0] RESET_BITS = 32'h0000_0000
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage_one;

	// First stage feeds only the second stage
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			stage_one <= RESET_BITS[WIDTH-1:0];
			sync_out  <= RESET_BITS[WIDTH-1:0];
		end else begin
			stage_one <= async_in;
			sync_out  <= stage_one;
		end
	end
endmodule : acd_sync

// ==== acd_command_decoder.sv ====
// Serial command decoder and configuration word of the converter
//
// Notes on behaviour
// - Word is 4-bit code plus 12-bit field
// - Codes 0 to 7 select input channels
// - Code 8 enters software power-down
// - Code 9 returns configuration in low bits
// - Code A loads configuration from same word
// - Codes B, C, D select test voltages
// - Code E reads FIFO, low nibble zero
// - Configuration survives every power-down state
// - Clock pause mid-write loses no state
// - Bit 11 picks internal or external reference
// - Bit 10 picks 2 V or 4 V
// - Bit 9 picks 12 or 24 clocks
// - Bits 8:7 pick conversion clock source
// - Bits 6:5 pick conversion mode
// - Bits 4:3 pick sweep order, sweeps only
// - Bit 2 picks interrupt or end-of-conversion
// - Bits 1:0 pick FIFO trigger level
// - First four output bits are don't care on code 9 reads
// - Sampling starts after conversion command decoded
`timescale 1ns/1ps
module acd_command_decoder (
	input  wire logic                       clock,
	input  wire logic                       rst_n,
	input  wire logic                       cs_n_pin,
	input  wire logic                       sclk_pin,
	input  wire logic                       sdi_pin,
	output logic                            sdo,
	output logic                            sdo_oe,
	input  wire logic [11:0]                result_word,
	output logic                            sample_start,
	output logic [2:0]                      selected_input,
	output acd_pkg::acd_test_input_type     test_input,
	output logic                            power_down,
	output logic                            fifo_pop,
	output logic                            config_written,
	output logic [11:0]                     configuration_word,
	output logic                            reference_internal,
	output logic                            reference_is_2v,
	output logic [4:0]                      sample_sclks,
	output acd_pkg::acd_conv_clock_type     conv_clock_source,
	output acd_pkg::acd_conv_mode_type      conv_mode,
	output logic [1:0]                      sweep_order,
	output logic                            sweep_enable,
	output logic                            status_pin_is_eoc,
	output logic                            fifo_used,
	output logic [2:0]                      fifo_trigger_level
);
	import acd_pkg::*;

	logic [2:0]          pins_sync;
	logic                cs_n_s;
	logic                sclk_s;
	logic                sdi_s;
	logic                sclk_prev;
	logic                cs_n_prev;
	acd_frame_state_type state;
	logic [4:0]          in_count;
	logic [3:0]          out_count;
	logic [14:0]         shift_in;
	logic [3:0]          operation_code;
	logic [15:0]         resp_word;

	// Pin inputs cross into the clock domain before use
	acd_sync #(
		.WIDTH      (3),
		.RESET_BITS (32'h0000_0004)
	) pin_sync (
		.clock    (clock),
		.rst_n    (rst_n),
		.async_in ({cs_n_pin, sclk_pin, sdi_pin}),
		.sync_out (pins_sync)
	);
	assign cs_n_s = pins_sync[2];
	assign sclk_s = pins_sync[1];
	assign sdi_s  = pins_sync[0];

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sclk_prev <= 1'b0;
			cs_n_prev <= 1'b1;
		end else begin
			sclk_prev <= sclk_s;
			cs_n_prev <= cs_n_s;
		end
	end

	wire sclk_rise  = sclk_s && !sclk_prev;
	wire sclk_fall  = !sclk_s && sclk_prev;
	wire cs_fall    = !cs_n_s && cs_n_prev;
	wire cs_rise    = cs_n_s && !cs_n_prev;
	wire in_frame   = (state == st_shift) && !cs_rise;
	wire bit_taken  = in_frame && sclk_rise && (in_count < 5'h10);
	wire [15:0] next_word = {shift_in, sdi_s};

	// Code is known once the fourth bit has been taken
	wire code_done  = bit_taken && (in_count == 5'h03);
	wire word_done  = bit_taken && (in_count == 5'h0f);
	wire [3:0] next_code = next_word[3:0];

	wire is_channel = (next_code <= OP_CHANNEL_LAST);
	wire is_test    = (next_code == OP_TEST_MID) ||
	                  (next_code == OP_TEST_LOW) ||
	                  (next_code == OP_TEST_HIGH);
	wire is_pdown   = (next_code == OP_POWER_DOWN);
	wire is_cfg_rd  = (next_code == OP_CONFIG_READ);

	wire cfg_load   = word_done && (operation_code == OP_CONFIG_WRITE);
	wire fifo_done  = word_done && (operation_code == OP_FIFO_READ);

	acd_test_input_type next_test;
	assign next_test = (next_code == OP_TEST_MID) ? test_midpoint :
	                   (next_code == OP_TEST_LOW) ? test_low_reference :
	                   test_high_reference;

	// Frame sequencing
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= st_idle;
		end else begin
			case (state)
				st_idle: begin
					if (cs_fall)
						state <= st_shift;
				end
				st_shift: begin
					if (cs_rise)
						state <= st_idle;
					else if (word_done)
						state <= st_done;
				end
				st_done: begin
					if (cs_rise)
						state <= st_idle;
				end
				default: state <= st_idle;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			in_count <= 5'h00;
			shift_in <= 15'h0000;
		end else if (cs_fall && state == st_idle) begin
			in_count <= 5'h00;
		end else if (bit_taken) begin
			in_count <= in_count + 5'h01;
			shift_in <= next_word[14:0];
		end
	end

	// top four bits form the code
	always_ff @(posedge clock) begin
		if (!rst_n)
			operation_code <= 4'h0;
		else if (code_done)
			operation_code <= next_code;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sample_start   <= 1'b0;
			selected_input <= 3'h0;
			test_input     <= test_none;
		end else begin
			sample_start <= code_done && (is_channel || is_test);
			if (code_done && is_channel) begin
				selected_input <= next_code[2:0];
				test_input     <= test_none;
			end else if (code_done && is_test) begin
				test_input <= next_test;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			power_down <= 1'b0;
		else if (code_done && is_pdown)
			power_down <= 1'b1;
		else if (code_done && (is_channel || is_test))
			power_down <= 1'b0;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			configuration_word <= CONFIG_RESET;
			config_written     <= 1'b0;
		end else begin
			config_written <= cfg_load;
			if (cfg_load)
				configuration_word <= next_word[11:0];
		end
	end

	// FIFO entry consumed when read ends
	always_ff @(posedge clock) begin
		if (!rst_n)
			fifo_pop <= 1'b0;
		else
			fifo_pop <= fifo_done;
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			resp_word <= 16'h0000;
		else if (cs_fall && state == st_idle)
			resp_word <= {result_word, 4'h0};
		else if (code_done && is_cfg_rd)
			resp_word <= {resp_word[15:12], configuration_word};
	end

	// Output index lags input by half a clock
	wire [3:0] out_index = 4'(4'he - out_count);
	// Not gated by state: the sixteenth fall comes while in the done state
	wire       last_fall = sdo_oe && sclk_fall && (out_count == 4'hf);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			out_count <= 4'h0;
			sdo       <= 1'b0;
			sdo_oe    <= 1'b0;
		end else if (cs_fall && state == st_idle) begin
			out_count <= 4'h0;
			sdo       <= result_word[11];
			sdo_oe    <= 1'b1;
		end else if (cs_rise || last_fall) begin
			sdo_oe <= 1'b0;
		end else if (sdo_oe && sclk_fall) begin
			out_count <= out_count + 4'h1;
			sdo       <= resp_word[out_index];
		end
	end

	assign reference_internal = configuration_word[CFG_REF_SOURCE_BIT];
	assign reference_is_2v    = configuration_word[CFG_REF_LEVEL_BIT];
	assign sample_sclks = configuration_word[CFG_SAMPLE_BIT] ?
	                      LONG_SAMPLE_SCLKS : SHORT_SAMPLE_SCLKS;
	assign conv_clock_source = acd_conv_clock_type'(
		configuration_word[CFG_CLOCK_MSB:CFG_CLOCK_LSB]);
	// conversion mode, FIFO idle in single shot
	assign conv_mode = acd_conv_mode_type'(
		configuration_word[CFG_MODE_MSB:CFG_MODE_LSB]);
	assign fifo_used = (conv_mode != mode_single_shot);
	// order only matters in sweep modes
	assign sweep_order  = configuration_word[CFG_SWEEP_MSB:CFG_SWEEP_LSB];
	assign sweep_enable = (conv_mode == mode_sweep) ||
	                      (conv_mode == mode_repeat_sweep);
	assign status_pin_is_eoc = configuration_word[CFG_PIN_FUNC_BIT];

	// trigger level, zero when FIFO unused
	wire [1:0] trig_code =
		configuration_word[CFG_TRIGGER_MSB:CFG_TRIGGER_LSB];
	wire [2:0] trig_level =
		(trig_code == 2'h0) ? TRIGGER_LEVEL_FULL :
		(trig_code == 2'h1) ? TRIGGER_LEVEL_3Q :
		(trig_code == 2'h2) ? TRIGGER_LEVEL_HALF :
		TRIGGER_LEVEL_QUARTER;
	assign fifo_trigger_level = fifo_used ? trig_level : 3'h0;

	// Checks on the decode and configuration paths
	cfg_write_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		cfg_load |=> configuration_word == $past(next_word[11:0])
		             && config_written)
		else $error("configuration write not applied");

	cfg_hold_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		!cfg_load |=> $stable(configuration_word))
		else $error("configuration changed without a write");

	chan_select_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		(code_done && is_channel) |=> sample_start
		  && selected_input == $past(next_code[2:0])
		  && test_input == test_none ##1 !sample_start)
		else $error("channel select decode wrong");

	test_select_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		(code_done && next_code == OP_TEST_LOW) |=>
		  sample_start && test_input == test_low_reference)
		else $error("test input decode wrong");

	power_down_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		(code_done && is_pdown) |=> power_down && !sample_start)
		else $error("power-down not entered");

	reserved_op_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		(code_done && next_code == OP_RESERVED) |=>
		  !sample_start && $stable(power_down)
		  && $stable(selected_input))
		else $error("reserved code had an effect");

	cfg_read_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		(code_done && is_cfg_rd) |=>
		  resp_word[11:0] == configuration_word)
		else $error("configuration not presented on output");

	fifo_nibble_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		(cs_fall && state == st_idle) |=> resp_word[3:0] == 4'h0
		  && resp_word[15:4] == $past(result_word) && sdo_oe)
		else $error("FIFO word framing wrong");

	pause_hold_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		(state == st_shift && !sclk_rise && !cs_rise) |=>
		  $stable(in_count) && $stable(shift_in))
		else $error("state lost while serial clock paused");

	trigger_map_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		(fifo_used && trig_code == 2'h1) |->
		  fifo_trigger_level == 3'h5)
		else $error("trigger level mapping wrong");

	cover_write_c: cover property (@(posedge clock) cfg_load);
	cover_read_c: cover property (@(posedge clock)
		code_done && is_cfg_rd);
	cover_fifo_c: cover property (@(posedge clock) fifo_done);
	cover_sample_c: cover property (@(posedge clock)
		code_done && is_channel);
endmodule : acd_command_decoder

// ==== acd_host_model.sv ====
// Host serial port model that frames words to the command decoder
`timescale 1ns/1ps
module acd_host_model (
	input  wire logic clock,
	input  wire logic sdo,
	input  wire logic sdo_oe,
	output logic      cs_n_pin,
	output logic      sclk_pin,
	output logic      sdi_pin
);
	// Each serial clock phase spans five system clocks, above the minimum
	localparam int HALF = 5;

	// Output enable seen just before chip select is released
	logic oe_at_end = 1'b0;

	initial begin
		cs_n_pin = 1'b1;
		sclk_pin = 1'b0;
		sdi_pin  = 1'b0;
	end

	task automatic frame(input logic [15:0] word, input int nbits,
		input int pause_at, output logic [15:0] resp);
		resp = 16'h0000;
		@(posedge clock);
		cs_n_pin <= 1'b0;
		repeat (8) @(posedge clock);
		for (int i = 0; i < nbits; i++) begin
			sdi_pin <= word[15-i];
			repeat (HALF) @(posedge clock);
			resp[15-i] = sdo_oe ? sdo : 1'b0;
			sclk_pin <= 1'b1;
			repeat (HALF) @(posedge clock);
			sclk_pin <= 1'b0;
			if (i == pause_at) begin
				repeat (40) @(posedge clock);
			end
		end
		repeat (HALF) @(posedge clock);
		oe_at_end = sdo_oe;
		cs_n_pin <= 1'b1;
		repeat (6) @(posedge clock);
	endtask : frame
endmodule : acd_host_model

// ==== tb_top.sv ====
// Self-checking bench for the converter command decoder
`timescale 1ns/1ps
module tb_top;
	import acd_pkg::*;
	logic               clock       = 1'b0;
	logic               rst_n       = 1'b0;
	logic [11:0]        result_word = 12'h5c3;
	logic               cs_n_pin;
	logic               sclk_pin;
	logic               sdi_pin;
	logic               sdo;
	logic               sdo_oe;
	logic               sample_start;
	logic [2:0]         selected_input;
	acd_test_input_type test_input;
	logic               power_down;
	logic               fifo_pop;
	logic               config_written;
	logic [11:0]        configuration_word;
	logic               reference_internal;
	logic               reference_is_2v;
	logic [4:0]         sample_sclks;
	acd_conv_clock_type conv_clock_source;
	acd_conv_mode_type  conv_mode;
	logic [1:0]         sweep_order;
	logic               sweep_enable;
	logic               status_pin_is_eoc;
	logic               fifo_used;
	logic [2:0]         fifo_trigger_level;
	logic [15:0]        resp;
	int                 mismatches      = 0;
	int                 samples_checked = 0;
	int                 starts          = 0;
	int                 pops            = 0;
	int                 writes          = 0;

	always #50 clock = ~clock;

	acd_command_decoder i_acd_command_decoder (
		.clock(clock), .rst_n(rst_n), .cs_n_pin(cs_n_pin),
		.sclk_pin(sclk_pin), .sdi_pin(sdi_pin), .sdo(sdo), .sdo_oe(sdo_oe),
		.result_word(result_word), .sample_start(sample_start),
		.selected_input(selected_input), .test_input(test_input),
		.power_down(power_down), .fifo_pop(fifo_pop),
		.config_written(config_written),
		.configuration_word(configuration_word),
		.reference_internal(reference_internal),
		.reference_is_2v(reference_is_2v), .sample_sclks(sample_sclks),
		.conv_clock_source(conv_clock_source), .conv_mode(conv_mode),
		.sweep_order(sweep_order), .sweep_enable(sweep_enable),
		.status_pin_is_eoc(status_pin_is_eoc), .fifo_used(fifo_used),
		.fifo_trigger_level(fifo_trigger_level));

	acd_host_model i_acd_host_model (
		.clock(clock), .sdo(sdo), .sdo_oe(sdo_oe), .cs_n_pin(cs_n_pin),
		.sclk_pin(sclk_pin), .sdi_pin(sdi_pin));

	// Pulses are one cycle wide, so counting them catches doubles and misses
	always @(posedge clock) begin
		if (rst_n && sample_start === 1'b1) starts++;
		if (rst_n && fifo_pop === 1'b1) pops++;
		if (rst_n && config_written === 1'b1) writes++;
	end

	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_val

	task automatic send(input logic [15:0] w, input int n = 16,
		input int p = -1);
		i_acd_host_model.frame(w, n, p, resp);
	endtask : send

	task automatic check_fields(input logic [11:0] w);
		check_val(16'(configuration_word), 16'(w));
		check_val(16'(reference_internal), 16'(w[11]));
		check_val(16'(reference_is_2v), 16'(w[10]));
		check_val(16'(sample_sclks), w[9] ? 16'h0018 : 16'h000c);
		check_val(16'(conv_clock_source), 16'(w[8:7]));
		check_val(16'(conv_mode), 16'(w[6:5]));
		check_val(16'(sweep_order), 16'(w[4:3]));
		check_val(16'(sweep_enable), 16'(w[6]));
		check_val(16'(status_pin_is_eoc), 16'(w[2]));
		check_val(16'(fifo_used), 16'(w[6:5] != 2'b00));
		check_val(16'(fifo_trigger_level), (w[6:5] == 2'b00) ? 16'h0000 :
			16'(7 - 2 * w[1:0]));
	endtask : check_fields

	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report

	initial begin
		// Two edges in reset load every flop, synchronisers included
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		check_fields(12'h000);
		check_val(16'(power_down), 16'h0000);
		// Every field code, each write paused after eight bits
		for (int k = 0; k < 4; k++) begin
			send({4'ha, 12'(k * 12'h555)}, 16, 7);
			check_fields(12'(k * 12'h555));
		end
		send(16'had9b);
		send(16'h9000);
		check_val(16'(resp[11:0]), 16'h0d9b);
		check_val(16'(i_acd_host_model.oe_at_end), 16'h0000);
		for (int c = 0; c < 8; c++) begin
			send({4'(c), 12'h000});
			check_val(16'(selected_input), 16'(c));
			check_val(16'(test_input), 16'(test_none));
			check_val(16'(starts), 16'(c + 1));
		end
		send(16'h8000);
		check_val(16'(power_down), 16'h0001);
		check_fields(12'hd9b);
		for (int t = 1; t < 4; t++) begin
			send({4'(4'ha + t), 12'h000});
			check_val(16'(test_input), 16'(t));
			check_val(16'(power_down), 16'h0000);
		end
		result_word <= 12'ha5e;
		send(16'he000);
		check_val(resp, 16'ha5e0);
		check_val(16'(pops), 16'h0001);
		send(16'hf555);
		// Write cut short after ten bits must not land
		send(16'ha777, 10);
		check_val(16'(i_acd_host_model.oe_at_end), 16'h0001);
		check_fields(12'hd9b);
		check_val(16'(starts), 16'h000b);
		check_val(16'(writes), 16'h0005);
		final_report();
	end

	// About 21 frames of some 180 cycles each; allow five times that
	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		final_report();
	end
endmodule : tb_top
